// File: src/bfp_pkg.sv
// Constants, register map and state types for the bidirectional frame protocol block
package bfp_pkg;

  // Control codes on the serial side, and the pad byte for a lone last byte in the buffer
  localparam logic [7:0] CODE_ENQ = 8'h05;
  localparam logic [7:0] CODE_ACK = 8'h06;
  localparam logic [7:0] CODE_NAK = 8'h15;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // Register indexes; byte address is four times the index
  localparam int IDX_W = 11;
  localparam logic [10:0] IDX_CTRL = 11'h0A0;
  localparam logic [10:0] IDX_SEND_CMD = 11'h0A1;
  localparam logic [10:0] IDX_RECV_CMD = 11'h0A2;
  localparam logic [10:0] IDX_RECV_ALLOW = 11'h0A3;
  localparam logic [10:0] IDX_SEND_RESULT = 11'h257;
  localparam logic [10:0] IDX_RECV_RESULT = 11'h258;
  localparam logic [10:0] IDX_SEND_COUNT = 11'h400;
  localparam logic [10:0] IDX_SEND_DATA = 11'h401;
  localparam logic [10:0] IDX_RECV_COUNT = 11'h600;
  localparam logic [10:0] IDX_RECV_DATA = 11'h601;

  // Buffer memory covers indexes 400h..7FFh; this index bit selects it
  localparam int MEM_AW = 10;
  localparam int MEM_SEL_BIT = 10;

  // Receive area holds this many payload bytes
  localparam logic [16:0] RECV_CAP_BYTES = 17'h003FE;

  // Field positions
  localparam int CTRL_SUM_BIT = 0;
  localparam int CTRL_BYTE_BIT = 1;
  localparam int CMD_GO_BIT = 0;

  // Reset values
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [15:0] ALLOW_RESET = 16'h01FF;
  localparam logic [15:0] RESULT_OK = 16'h0000;

  // Error codes the device itself sends
  localparam logic [15:0] ERR_LENGTH = 16'h7E01;
  localparam logic [15:0] ERR_SUM = 16'h7E02;

  // Receive side states
  typedef enum logic [3:0] {
    RX_IDLE = 4'h0,
    RX_LEN_L = 4'h1,
    RX_LEN_H = 4'h2,
    RX_DATA = 4'h3,
    RX_SUM_L = 4'h4,
    RX_SUM_H = 4'h5,
    RX_DONE = 4'h6,
    RX_NAK_L = 4'h7,
    RX_NAK_H = 4'h8
  } bfp_rx_state_e;

  // Transmit side states
  typedef enum logic [3:0] {
    TX_IDLE = 4'h0,
    TX_ERR_L = 4'h1,
    TX_ERR_H = 4'h2,
    TX_FETCH_CNT = 4'h3,
    TX_ENQ = 4'h4,
    TX_LEN_L = 4'h5,
    TX_LEN_H = 4'h6,
    TX_FETCH = 4'h7,
    TX_DATA = 4'h8,
    TX_SUM_L = 4'h9,
    TX_SUM_H = 4'hA,
    TX_WAIT = 4'hB
  } bfp_tx_state_e;

  // Length field value converted to a byte count
  function automatic logic [16:0] to_bytes(input logic [15:0] n, input logic byte_unit);
    return byte_unit ? {1'b0, n} : {n, 1'b0};
  endfunction : to_bytes

endpackage : bfp_pkg

// File: src/bfp_mem_if.sv
// Buffer memory ports shared between the framer and its memory
`timescale 1ns/100ps
interface bfp_mem_if;
  logic we; // One write port, engine has priority over the bus
  logic [bfp_pkg::MEM_AW-1:0] waddr;
  logic [15:0] wdata;
  logic [bfp_pkg::MEM_AW-1:0] raddr_a; // Bus read port
  logic [15:0] rdata_a;
  logic [bfp_pkg::MEM_AW-1:0] raddr_b; // Transmit engine read port
  logic [15:0] rdata_b;
  modport ctrl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : bfp_mem_if

// File: src/bfp_mem.sv
// Buffer memory for the transmit and receive areas, registered reads
`timescale 1ns/100ps
module bfp_mem #(
  parameter int AW = bfp_pkg::MEM_AW
) (
  input wire logic clk,
  bfp_mem_if.mem mp
);
  // Storage; contents are not reset, software and the receiver fill them
  logic [15:0] mem_q [0:(1<<AW)-1];
  logic [15:0] rdata_a_reg;
  logic [15:0] rdata_b_reg;

  // Write port and two registered read ports
  always_ff @(posedge clk) begin
    if (mp.we) begin
      mem_q[mp.waddr] <= mp.wdata;
    end
    rdata_a_reg <= mem_q[mp.raddr_a];
    rdata_b_reg <= mem_q[mp.raddr_b];
  end

  assign mp.rdata_a = rdata_a_reg;
  assign mp.rdata_b = rdata_b_reg;
endmodule : bfp_mem

// File: src/bfp_top.sv
// Bidirectional frame protocol engine with AHB-Lite register access
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
module bfp_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic receive_read_request_flag,
  output logic module_ready_flag,
  output logic read_done_marker
);
  // Memory carrier
  bfp_mem_if mif ();

  bfp_mem #(.AW(bfp_pkg::MEM_AW)) bfp_mem_i (
    .clk(clk),
    .mp(mif.mem)
  );

  // Bus data phase state
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [10:0] dp_idx_reg;
  logic rd_wait_reg;

  // Software visible registers
  logic [1:0] ctrl_reg;
  logic [15:0] allow_reg;
  logic [15:0] send_result_reg;
  logic [15:0] recv_result_reg;
  logic ready_reg;

  // Handshake flags between bus, receiver and transmitter
  logic req_reg; // Receive read request toward host
  logic ack_pend_reg; // ACK owed after host read
  logic nak_pend_reg; // NAK owed after bad frame
  logic [15:0] nak_code_reg;
  logic send_pend_reg;
  logic send_busy_reg;
  logic send_done_reg;
  logic send_err_reg;
  logic rd_done_reg;

  // Receiver state
  bfp_pkg::bfp_rx_state_e rx_state_reg, rx_state_next;
  logic [15:0] len_reg, len_next;
  logic [16:0] total_reg, total_next;
  logic [16:0] bidx_reg, bidx_next;
  logic [7:0] lo_reg, lo_next;
  logic [15:0] sum_reg, sum_next;
  logic [15:0] code_reg, code_next; // Pending error for this frame, zero if none

  // Transmitter state
  bfp_pkg::bfp_tx_state_e tx_state_reg, tx_state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [16:0] ttot_reg, ttot_next;
  logic [16:0] tidx_reg, tidx_next;
  logic [15:0] tsum_reg, tsum_next;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic tx_load;
  logic [7:0] tx_byte;

  // Event strobes from the two engines
  logic resp_ack;
  logic resp_nak;
  logic frame_ok;
  logic frame_bad;
  logic nak_taken;
  logic ack_taken;
  logic send_taken;
  logic send_end;

  // Bus decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire bus_wr_try = dp_valid_reg & dp_write_reg;
  logic eng_we; // Receiver owns the write port this cycle
  wire bus_wr = bus_wr_try & ~eng_we;
  wire [10:0] ap_idx = haddr[12:2];
  wire dp_is_mem = dp_idx_reg[bfp_pkg::MEM_SEL_BIT];
  wire wr_ctrl = bus_wr & (dp_idx_reg == bfp_pkg::IDX_CTRL);
  wire wr_allow = bus_wr & (dp_idx_reg == bfp_pkg::IDX_RECV_ALLOW);
  wire wr_send = bus_wr & (dp_idx_reg == bfp_pkg::IDX_SEND_CMD) & hwdata[bfp_pkg::CMD_GO_BIT];
  wire wr_read = bus_wr & (dp_idx_reg == bfp_pkg::IDX_RECV_CMD) & hwdata[bfp_pkg::CMD_GO_BIT];
  wire sum_en = ctrl_reg[bfp_pkg::CTRL_SUM_BIT];
  wire byte_unit = ctrl_reg[bfp_pkg::CTRL_BYTE_BIT];
  wire [16:0] allow_bytes = bfp_pkg::to_bytes(allow_reg, byte_unit);

  // Register read mux; all sources are flops
  logic [15:0] reg_rdata;
  always_comb begin
    unique case (dp_idx_reg)
      bfp_pkg::IDX_CTRL: reg_rdata = {14'h0000, ctrl_reg};
      bfp_pkg::IDX_RECV_ALLOW: reg_rdata = allow_reg;
      bfp_pkg::IDX_SEND_CMD: reg_rdata = {13'h0000, send_err_reg, send_done_reg, send_busy_reg};
      bfp_pkg::IDX_RECV_CMD: reg_rdata = {13'h0000, rd_done_reg, ack_pend_reg, req_reg};
      bfp_pkg::IDX_SEND_RESULT: reg_rdata = send_result_reg;
      bfp_pkg::IDX_RECV_RESULT: reg_rdata = recv_result_reg;
      default: reg_rdata = 16'h0000; // Unmapped reads as zero
    endcase
  end

  // Reads take one wait cycle so a write just before is always seen
  assign hreadyout = ~dp_valid_reg | (dp_write_reg ? ~eng_we : rd_wait_reg);
  assign hresp = 1'b0;
  assign hrdata = {16'h0000, dp_is_mem ? mif.rdata_a : reg_rdata};
  assign mif.raddr_a = dp_idx_reg[bfp_pkg::MEM_AW-1:0];

  // Bus data phase tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg <= 11'h000;
      rd_wait_reg <= 1'b0;
    end else begin
      rd_wait_reg <= dp_valid_reg & ~dp_write_reg & ~rd_wait_reg;
      if (hready) begin
        dp_valid_reg <= addr_phase;
        dp_write_reg <= hwrite;
        dp_idx_reg <= ap_idx;
      end
    end
  end

  // Receiver write port: payload words and the count word
  wire rx_last = (bidx_reg + 17'h00001) == total_reg;
  wire rx_store = (code_reg == bfp_pkg::RESULT_OK) & (bidx_reg < allow_bytes);
  wire [bfp_pkg::MEM_AW-1:0] rx_word_addr =
    bfp_pkg::IDX_RECV_DATA[bfp_pkg::MEM_AW-1:0] + {1'b0, bidx_reg[9:1]};
  wire data_we = (rx_state_reg == bfp_pkg::RX_DATA) & rx_valid & rx_store & (bidx_reg[0] | rx_last);
  wire cnt_we = (rx_state_reg == bfp_pkg::RX_DONE) & (code_reg == bfp_pkg::RESULT_OK);
  wire [15:0] rx_count = (len_reg > allow_reg) ? allow_reg : len_reg;
  // First byte lands in the low half; a lone last byte gets a zero upper half
  wire [15:0] rx_word = bidx_reg[0] ? {rx_data, lo_reg} : {bfp_pkg::PAD_BYTE, rx_data};
  assign eng_we = data_we | cnt_we;
  // Bus writes reach the buffer only when the receiver leaves the port free
  wire mem_bus_we = bus_wr & dp_is_mem;
  assign mif.we = eng_we | mem_bus_we;
  assign mif.waddr = data_we ? rx_word_addr : (cnt_we ? bfp_pkg::IDX_RECV_COUNT[bfp_pkg::MEM_AW-1:0]
    : dp_idx_reg[bfp_pkg::MEM_AW-1:0]);
  assign mif.wdata = data_we ? rx_word : (cnt_we ? rx_count : hwdata[15:0]);
  wire tx_wait = tx_state_reg == bfp_pkg::TX_WAIT;
  assign frame_ok = cnt_we;
  assign frame_bad = (rx_state_reg == bfp_pkg::RX_DONE) & (code_reg != bfp_pkg::RESULT_OK);

  // Receiver next state; control codes and sum are consumed here, never stored
  always_comb begin
    rx_state_next = rx_state_reg;
    len_next = len_reg;
    total_next = total_reg;
    bidx_next = bidx_reg;
    lo_next = lo_reg;
    sum_next = sum_reg;
    code_next = code_reg;
    resp_ack = 1'b0;
    resp_nak = 1'b0;
    unique case (rx_state_reg)
      bfp_pkg::RX_IDLE: begin
        // Anything but ENQ, or ACK/NAK while a sent frame waits, is dropped here, covering trailing bytes
        if (rx_valid) begin
          if (rx_data == bfp_pkg::CODE_ENQ) begin
            rx_state_next = bfp_pkg::RX_LEN_L;
            sum_next = 16'h0000;
            code_next = bfp_pkg::RESULT_OK;
          end else if (tx_wait & (rx_data == bfp_pkg::CODE_ACK)) begin
            resp_ack = 1'b1;
          end else if (tx_wait & (rx_data == bfp_pkg::CODE_NAK)) begin
            rx_state_next = bfp_pkg::RX_NAK_L;
          end
        end
      end
      bfp_pkg::RX_LEN_L: begin
        if (rx_valid) begin
          len_next = {8'h00, rx_data};
          sum_next = sum_reg + {8'h00, rx_data};
          rx_state_next = bfp_pkg::RX_LEN_H;
        end
      end
      bfp_pkg::RX_LEN_H: begin
        if (rx_valid) begin
          len_next = {rx_data, len_reg[7:0]};
          total_next = bfp_pkg::to_bytes({rx_data, len_reg[7:0]}, byte_unit);
          sum_next = sum_reg + {8'h00, rx_data};
          bidx_next = 17'h00000;
          // Frame too long for the receive area is consumed and refused
          if (bfp_pkg::to_bytes({rx_data, len_reg[7:0]}, byte_unit) > bfp_pkg::RECV_CAP_BYTES) begin
            code_next = bfp_pkg::ERR_LENGTH;
          end
          if (bfp_pkg::to_bytes({rx_data, len_reg[7:0]}, byte_unit) == 17'h00000) begin
            rx_state_next = sum_en ? bfp_pkg::RX_SUM_L : bfp_pkg::RX_DONE;
          end else begin
            rx_state_next = bfp_pkg::RX_DATA;
          end
        end
      end
      bfp_pkg::RX_DATA: begin
        // Any byte value is payload here, including code values
        if (rx_valid) begin
          lo_next = rx_data;
          sum_next = sum_reg + {8'h00, rx_data};
          bidx_next = bidx_reg + 17'h00001;
          if (rx_last) begin
            rx_state_next = sum_en ? bfp_pkg::RX_SUM_L : bfp_pkg::RX_DONE;
          end
        end
      end
      bfp_pkg::RX_SUM_L: begin
        if (rx_valid) begin
          lo_next = rx_data;
          rx_state_next = bfp_pkg::RX_SUM_H;
        end
      end
      bfp_pkg::RX_SUM_H: begin
        if (rx_valid) begin
          if (({rx_data, lo_reg} != sum_reg) & (code_reg == bfp_pkg::RESULT_OK)) begin
            code_next = bfp_pkg::ERR_SUM;
          end
          rx_state_next = bfp_pkg::RX_DONE;
        end
      end
      bfp_pkg::RX_DONE: begin
        rx_state_next = bfp_pkg::RX_IDLE;
      end
      bfp_pkg::RX_NAK_L: begin
        if (rx_valid) begin
          lo_next = rx_data;
          rx_state_next = bfp_pkg::RX_NAK_H;
        end
      end
      bfp_pkg::RX_NAK_H: begin
        if (rx_valid) begin
          resp_nak = 1'b1;
          rx_state_next = bfp_pkg::RX_IDLE;
        end
      end
      default: rx_state_next = bfp_pkg::RX_IDLE;
    endcase
  end

  // Transmitter: one byte register, loaded when empty or being taken
  wire tx_free = ~tx_valid_reg | tx_ready;
  wire tx_tlast = (tidx_reg + 17'h00001) == ttot_reg;
  assign mif.raddr_b = (tx_state_reg == bfp_pkg::TX_FETCH_CNT) ? bfp_pkg::IDX_SEND_COUNT[bfp_pkg::MEM_AW-1:0]
    : bfp_pkg::IDX_SEND_DATA[bfp_pkg::MEM_AW-1:0] + {1'b0, tidx_reg[9:1]};
  wire [7:0] tx_pick = tidx_reg[0] ? mif.rdata_b[15:8] : mif.rdata_b[7:0];

  // Transmitter next state
  always_comb begin
    tx_state_next = tx_state_reg;
    cnt_next = cnt_reg;
    ttot_next = ttot_reg;
    tidx_next = tidx_reg;
    tsum_next = tsum_reg;
    tx_load = 1'b0;
    tx_byte = tx_data_reg;
    nak_taken = 1'b0;
    ack_taken = 1'b0;
    send_taken = 1'b0;
    unique case (tx_state_reg)
      bfp_pkg::TX_IDLE: begin
        // Responses go ahead of a new frame while the byte register is free; when it is busy a pending send starts first
        if (tx_free & nak_pend_reg) begin
          tx_load = 1'b1;
          tx_byte = bfp_pkg::CODE_NAK;
          nak_taken = 1'b1;
          tx_state_next = bfp_pkg::TX_ERR_L;
        end else if (tx_free & ack_pend_reg) begin
          tx_load = 1'b1;
          tx_byte = bfp_pkg::CODE_ACK;
          ack_taken = 1'b1;
        end else if (send_pend_reg) begin
          send_taken = 1'b1;
          tsum_next = 16'h0000;
          tx_state_next = bfp_pkg::TX_FETCH_CNT;
        end
      end
      bfp_pkg::TX_ERR_L: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = nak_code_reg[7:0];
          tx_state_next = bfp_pkg::TX_ERR_H;
        end
      end
      bfp_pkg::TX_ERR_H: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = nak_code_reg[15:8];
          tx_state_next = bfp_pkg::TX_IDLE;
        end
      end
      bfp_pkg::TX_FETCH_CNT: tx_state_next = bfp_pkg::TX_ENQ;
      bfp_pkg::TX_ENQ: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = bfp_pkg::CODE_ENQ;
          cnt_next = mif.rdata_b;
          ttot_next = bfp_pkg::to_bytes(mif.rdata_b, byte_unit);
          tx_state_next = bfp_pkg::TX_LEN_L;
        end
      end
      bfp_pkg::TX_LEN_L: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = cnt_reg[7:0];
          tsum_next = tsum_reg + {8'h00, cnt_reg[7:0]};
          tx_state_next = bfp_pkg::TX_LEN_H;
        end
      end
      bfp_pkg::TX_LEN_H: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = cnt_reg[15:8];
          tsum_next = tsum_reg + {8'h00, cnt_reg[15:8]};
          tidx_next = 17'h00000;
          if (ttot_reg == 17'h00000) begin
            tx_state_next = sum_en ? bfp_pkg::TX_SUM_L : bfp_pkg::TX_WAIT;
          end else begin
            tx_state_next = bfp_pkg::TX_FETCH;
          end
        end
      end
      bfp_pkg::TX_FETCH: tx_state_next = bfp_pkg::TX_DATA;
      bfp_pkg::TX_DATA: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = tx_pick;
          tsum_next = tsum_reg + {8'h00, tx_pick};
          tidx_next = tidx_reg + 17'h00001;
          if (tx_tlast) begin
            tx_state_next = sum_en ? bfp_pkg::TX_SUM_L : bfp_pkg::TX_WAIT;
          end else begin
            tx_state_next = bfp_pkg::TX_FETCH;
          end
        end
      end
      bfp_pkg::TX_SUM_L: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = tsum_reg[7:0];
          tx_state_next = bfp_pkg::TX_SUM_H;
        end
      end
      bfp_pkg::TX_SUM_H: begin
        if (tx_free) begin
          tx_load = 1'b1;
          tx_byte = tsum_reg[15:8];
          tx_state_next = bfp_pkg::TX_WAIT;
        end
      end
      bfp_pkg::TX_WAIT: begin
        if (resp_ack | resp_nak) begin
          tx_state_next = bfp_pkg::TX_IDLE;
        end
      end
      default: tx_state_next = bfp_pkg::TX_IDLE;
    endcase
  end
  assign send_end = resp_ack | resp_nak;

  // Engine state registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_reg <= bfp_pkg::RX_IDLE;
      len_reg <= 16'h0000;
      total_reg <= 17'h00000;
      bidx_reg <= 17'h00000;
      lo_reg <= 8'h00;
      sum_reg <= 16'h0000;
      code_reg <= 16'h0000;
      tx_state_reg <= bfp_pkg::TX_IDLE;
      cnt_reg <= 16'h0000;
      ttot_reg <= 17'h00000;
      tidx_reg <= 17'h00000;
      tsum_reg <= 16'h0000;
    end else begin
      rx_state_reg <= rx_state_next;
      len_reg <= len_next;
      total_reg <= total_next;
      bidx_reg <= bidx_next;
      lo_reg <= lo_next;
      sum_reg <= sum_next;
      code_reg <= code_next;
      tx_state_reg <= tx_state_next;
      cnt_reg <= cnt_next;
      ttot_reg <= ttot_next;
      tidx_reg <= tidx_next;
      tsum_reg <= tsum_next;
    end
  end

  // Outgoing byte holding register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (tx_load) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= tx_byte;
    end else if (tx_ready) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // Configuration and result registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= bfp_pkg::CTRL_RESET;
      allow_reg <= bfp_pkg::ALLOW_RESET;
      send_result_reg <= bfp_pkg::RESULT_OK;
      recv_result_reg <= bfp_pkg::RESULT_OK;
      nak_code_reg <= bfp_pkg::RESULT_OK;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
      if (wr_ctrl) ctrl_reg <= hwdata[1:0];
      if (wr_allow) allow_reg <= hwdata[15:0];
      if (resp_ack) send_result_reg <= bfp_pkg::RESULT_OK;
      if (resp_nak) send_result_reg <= {rx_data, lo_reg};
      if (frame_bad) begin
        recv_result_reg <= code_reg;
        nak_code_reg <= code_reg;
      end
    end
  end

  // Flags; a hardware set always wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      nak_pend_reg <= 1'b0;
      send_pend_reg <= 1'b0;
      send_busy_reg <= 1'b0;
      send_done_reg <= 1'b0;
      send_err_reg <= 1'b0;
      rd_done_reg <= 1'b0;
    end else begin
      req_reg <= frame_ok | (req_reg & ~wr_read);
      // Read command without a pending request is ignored
      ack_pend_reg <= (wr_read & req_reg) | (ack_pend_reg & ~ack_taken);
      rd_done_reg <= ack_taken | (rd_done_reg & ~frame_ok);
      nak_pend_reg <= frame_bad | (nak_pend_reg & ~nak_taken);
      send_pend_reg <= (wr_send & ~send_busy_reg) | (send_pend_reg & ~send_taken);
      send_busy_reg <= (wr_send & ~send_busy_reg) | (send_busy_reg & ~send_end);
      send_done_reg <= send_end | (send_done_reg & ~wr_send);
      send_err_reg <= resp_nak | (send_err_reg & ~wr_send & ~resp_ack);
    end
  end

  // Bus fields this block does not decode
  wire unused_ok = (|hsize) | (|haddr[31:13]) | (|haddr[1:0]) | (|hwdata[31:16]);

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign receive_read_request_flag = req_reg;
  assign module_ready_flag = ready_reg & ~unused_ok | ready_reg;
  assign read_done_marker = ack_taken;
endmodule : bfp_top

// File: testbench/bfp_top_properties.sv
// Port-level checks for the frame protocol block
`timescale 1ns/100ps
module bfp_top_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic receive_read_request_flag,
  input wire logic module_ready_flag,
  input wire logic read_done_marker
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reads always take exactly one wait cycle
  AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_OKAY: assert property (hresp == 1'h0) else $error("hresp not okay");
  AST_HI_ZERO: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("hrdata upper half set");
  // An offered byte may not change before the far end takes it
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  AST_MARK_ONE: assert property (read_done_marker |=> !read_done_marker)
    else $error("marker too long");
  AST_MARK_ACK: assert property (read_done_marker |-> ##[1:40] (tx_valid && tx_data == 8'h06))
    else $error("no ack after read");
  AST_REQ_RX: assert property ($rose(receive_read_request_flag) |-> $past(rx_valid, 2))
    else $error("request without byte");
  AST_READY: assert property ($past(!sys_rst) |-> module_ready_flag)
    else $error("ready flag low");
endmodule : bfp_top_properties
bind bfp_top bfp_top_properties bfp_top_properties_i (.clk, .sys_rst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .rx_valid, .tx_valid, .tx_data, .tx_ready,
  .receive_read_request_flag, .module_ready_flag, .read_done_marker);

// File: testbench/bfp_serial_peer.sv
// Far-end serial device model: sends frames, takes bytes with stalls
`timescale 1ns/100ps
module bfp_serial_peer (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$]; // Bytes taken from the device
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'hA5;
    tx_ready = 1'h0;
  end
  // Ready every other cycle, so the device must hold its byte
  always @(posedge clk) begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // One pulse a byte; the idle line shows the inverse, not a stale value
  task automatic put(input logic [7:0] b);
    @(posedge clk) rx_valid <= 1'h1;
    rx_data <= b;
    @(posedge clk) rx_valid <= 1'h0;
    rx_data <= ~b;
  endtask : put
  // Byte-unit frame; bad is added to the sum to corrupt it
  task automatic frame(input logic [7:0] d[$], input logic sum, input logic [15:0] bad);
    logic [15:0] s;
    s = 16'(d.size()) + bad;
    put(8'h05);
    put(8'(d.size()));
    put(8'h00);
    foreach (d[i]) begin
      put(d[i]);
      s = s + 16'(d[i]);
    end
    if (sum) begin
      put(s[7:0]);
      put(s[15:8]);
    end
  endtask : frame
  // Negative answer, code kept inside the far end's range
  task automatic nak(input logic [15:0] c);
    put(8'h15);
    put(c[7:0]);
    put(c[15:8]);
  endtask : nak
endmodule : bfp_serial_peer

// File: testbench/tb_bfp_top.sv
// Self-checking bench: registers, receive, answer and send paths
`timescale 1ns/100ps
module tb_bfp_top;
  logic clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, rx_valid, tx_valid, tx_ready;
  logic receive_read_request_flag, module_ready_flag, read_done_marker;
  logic [7:0] rx_data, tx_data;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  // The single slave's hreadyout is the bus hready
  bfp_top bfp_top_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_valid, .rx_data, .tx_valid, .tx_data,
    .tx_ready, .receive_read_request_flag, .module_ready_flag, .read_done_marker);
  bfp_serial_peer bfp_serial_peer_i (.clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  task automatic finish_test;
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One single AHB-Lite transfer; waits on hready, no fixed latency
  task automatic bus(input logic w, input logic [10:0] ix, input logic [31:0] wd);
    @(posedge clk) hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {19'h0, ix, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [10:0] ix, input logic [31:0] e);
    bus(1'h0, ix, 32'h0);
    chk(rd, e);
  endtask : rchk
  // Compare what the far end took, then forget it
  task automatic txchk(input logic [7:0] e[$]);
    for (int k = 0; k < 400 && bfp_serial_peer_i.got.size() < e.size(); k++) @(posedge clk);
    chk(bfp_serial_peer_i.got.size(), e.size());
    foreach (e[i]) if (i < bfp_serial_peer_i.got.size()) chk(bfp_serial_peer_i.got[i], e[i]);
    bfp_serial_peer_i.got.delete();
  endtask : txchk
  task automatic wreq;
    for (int k = 0; k < 300 && receive_read_request_flag !== 1'h1; k++) @(posedge clk);
    chk(receive_read_request_flag, 1'h1);
  endtask : wreq
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    rchk(bfp_pkg::IDX_CTRL, 32'h1);
    chk(module_ready_flag, 1'h1);
    rchk(bfp_pkg::IDX_RECV_ALLOW, 32'h1FF);
    rchk(11'h0A9, 32'h0);
    bus(1'h1, bfp_pkg::IDX_CTRL, 32'h3);
    bfp_serial_peer_i.frame('{8'hAA, 8'h15, 8'hFF}, 1'h1, 16'h0);
    wreq();
    rchk(bfp_pkg::IDX_RECV_COUNT, 32'h3);
    rchk(bfp_pkg::IDX_RECV_DATA, 32'h15AA);
    rchk(11'h602, 32'h00FF);
    bus(1'h1, bfp_pkg::IDX_RECV_CMD, 32'h1);
    txchk('{8'h06});
    rchk(bfp_pkg::IDX_RECV_CMD, 32'h4);
    // Corrupted sum must be refused and reported
    bfp_serial_peer_i.frame('{8'h01}, 1'h1, 16'h1);
    txchk('{8'h15, 8'h02, 8'h7E});
    rchk(bfp_pkg::IDX_RECV_RESULT, 32'h7E02);
    chk(receive_read_request_flag, 1'h0);
    // No sum, allowance of two bytes, trailing junk
    bus(1'h1, bfp_pkg::IDX_CTRL, 32'h2);
    bus(1'h1, bfp_pkg::IDX_RECV_ALLOW, 32'h2);
    bfp_serial_peer_i.frame('{8'h10, 8'h20, 8'h30, 8'h40}, 1'h0, 16'h0);
    bfp_serial_peer_i.put(8'h77);
    wreq();
    rchk(bfp_pkg::IDX_RECV_COUNT, 32'h2);
    rchk(bfp_pkg::IDX_RECV_DATA, 32'h2010);
    rchk(11'h602, 32'h00FF);
    bus(1'h1, bfp_pkg::IDX_RECV_CMD, 32'h1);
    txchk('{8'h06});
    // Send three bytes with sum, far end refuses with its own code
    bus(1'h1, bfp_pkg::IDX_CTRL, 32'h3);
    bus(1'h1, bfp_pkg::IDX_SEND_COUNT, 32'h3);
    bus(1'h1, bfp_pkg::IDX_SEND_DATA, 32'h2211);
    bus(1'h1, 11'h402, 32'h0033);
    bus(1'h1, bfp_pkg::IDX_SEND_CMD, 32'h1);
    txchk('{8'h05, 8'h03, 8'h00, 8'h11, 8'h22, 8'h33, 8'h69, 8'h00});
    bfp_serial_peer_i.nak(16'h0022);
    rchk(bfp_pkg::IDX_SEND_RESULT, 32'h0022);
    rchk(bfp_pkg::IDX_SEND_CMD, 32'h6);
    // Word unit send of one word, far end accepts
    bus(1'h1, bfp_pkg::IDX_CTRL, 32'h1);
    bus(1'h1, bfp_pkg::IDX_SEND_COUNT, 32'h1);
    bus(1'h1, bfp_pkg::IDX_SEND_CMD, 32'h1);
    txchk('{8'h05, 8'h01, 8'h00, 8'h11, 8'h22, 8'h34, 8'h00});
    bfp_serial_peer_i.put(8'h06);
    rchk(bfp_pkg::IDX_SEND_RESULT, 32'h0);
    rchk(bfp_pkg::IDX_SEND_CMD, 32'h2);
    finish_test();
  end
endmodule : tb_bfp_top
